// file: design/wdog_counter.sv
// Watchdog period counter with period decode
`timescale 1ns/10ps
module wdog_counter (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       tick,
   input  wire logic       clear,
   input  wire logic [3:0] period_select,
   output logic            timeout
);
   import wdog_pkg::*;

   logic [CNT_W-1:0] count_q;

   // Last count of the period; reserved codes take the longest period
   function automatic logic [CNT_W-1:0] last_count(input logic [3:0] code);
      logic [3:0] c;
      c = (code > PSEL_MAX_VALID) ? PSEL_MAX_VALID : code;
      last_count = CNT_W'((32'h1 << (PERIOD_LOG2_BASE + int'(c))) - 32'h1);
   endfunction : last_count

   // =====================================================================
   // Counter
   // =====================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         count_q <= '0;
         timeout <= 1'b0;
      end else if (tick && count_q >= last_count(period_select)) begin
         count_q <= '0;
         timeout <= 1'b1;
      end else begin
         if (tick) begin
            count_q <= count_q + CNT_W'(1);
         end
         timeout <= 1'b0;
      end
   end

endmodule : wdog_counter

// file: design/wdog_pkg.sv
// Constants shared by the watchdog design files
package wdog_pkg;

   // =====================================================================
   // Clock rates
   // =====================================================================
   localparam int unsigned SYS_CLK_HZ  = 125_000_000;
   localparam int unsigned WDOSC_HZ    = 128_000;
   localparam int unsigned TICK_DIV    = SYS_CLK_HZ / WDOSC_HZ;

   // =====================================================================
   // Register indices and byte addresses
   // =====================================================================
   localparam logic [7:0] CTRL_INDEX   = 8'h21;
   localparam logic [7:0] STATUS_INDEX = 8'h22;
   localparam logic [7:0] CTRL_ADDR    = 8'(CTRL_INDEX * 4);
   localparam logic [7:0] STATUS_ADDR  = 8'(STATUS_INDEX * 4);

   // =====================================================================
   // watchdog_control fields
   // =====================================================================
   localparam int IRQ_FLAG_BIT  = 7;
   localparam int IRQ_EN_BIT    = 6;
   localparam int PSEL_HI_BIT   = 5;
   localparam int CHG_EN_BIT    = 4;
   localparam int WD_EN_BIT     = 3;
   localparam int PSEL_LO_MSB   = 2;

   // =====================================================================
   // reset_source_status fields
   // =====================================================================
   localparam int WDOG_FLAG_BIT = 3;
   localparam int BROWN_FLAG_BIT = 2;
   localparam int PIN_FLAG_BIT  = 1;
   localparam int PON_FLAG_BIT  = 0;
   localparam logic [3:0] STATUS_RSV_ZERO = 4'h0;

   // =====================================================================
   // Timing and period codes
   // =====================================================================
   localparam logic [2:0] CHG_EN_CYCLES = 3'h4;
   localparam logic [3:0] PSEL_MAX_VALID = 4'h9;
   localparam int PERIOD_LOG2_BASE = 11;
   localparam int CNT_W = 20;

   // =====================================================================
   // Bus answers
   // =====================================================================
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : wdog_pkg

// file: design/wdog_tick_gen.sv
// Divider making the one-cycle watchdog oscillator tick
`timescale 1ns/10ps
module wdog_tick_gen #(
   parameter int unsigned DIV = wdog_pkg::TICK_DIV
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   import wdog_pkg::*;

   logic [15:0] div_q;

   // =====================================================================
   // Divider
   // =====================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 16'h0;
         tick  <= 1'b0;
      end else if (div_q == 16'(DIV - 1)) begin
         div_q <= 16'h0;
         tick  <= 1'b1;
      end else begin
         div_q <= div_q + 16'h1;
         tick  <= 1'b0;
      end
   end

endmodule : wdog_tick_gen

// file: design/wdog_top.sv
// Watchdog timer with reset source flags behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps

// Notes on behaviour
// - Status bits 7:4 always read zero.
// - Watchdog reset sets bit 3; power-on or written zero clears it.
// - Brown-out reset sets bit 2; power-on or written zero clears it.
// - Pin reset sets bit 1; power-on or written zero clears it.
// - Power-on sets bit 0; only a written zero clears it.
// - Interrupt-mode time-out sets flag; vector taken or written one clears it.
// - Interrupt requested only with flag, enable and global enable all set.
// - Enable and interrupt enable choose stop, interrupt, reset or flag then reset (wdog_irq stays low).
// - With enable set, a time-out clears the interrupt enable.
// - Change enable clears itself four clock cycles after being written one.
// - Enable can be cleared only while change enable is one.
// - Period select changes only while change enable is set.
// - In safety level 2 the watchdog can never be disabled.
// - In safety level 1 the watchdog reset flag forces enable on.
// - Period codes 0 to 9 give 2048 to 1048576 ticks, doubling.
// - Reserved period codes fall back to a valid period.
// - Counter runs from the 128 kHz oscillator tick, not the system clock.
// - A reset-mode time-out gives a one-cycle reset pulse.
// - Counter clears on restart, when disabled and on any device reset.
module wdog_top #(
   parameter int unsigned TICK_DIV = wdog_pkg::TICK_DIV
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   // AXI4-Lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Processor side
   input  wire logic        wdog_restart,
   input  wire logic        cpu_irq_enable,
   input  wire logic        irq_taken,
   input  wire logic        brownout_rst_evt,
   input  wire logic        pin_rst_evt,
   input  wire logic        safety_level_fuse,
   output logic             wdog_irq,
   output logic             wdog_reset_pulse
);
   import wdog_pkg::*;

   // =====================================================================
   // Declarations
   // =====================================================================
   logic        aw_held_q;
   logic [7:0]  awaddr_q;
   logic        w_held_q;
   logic [7:0]  wdata_q;
   logic        wstrb0_q;
   logic        wr_fire;
   logic        ctrl_wr;
   logic        status_wr;
   logic        ar_fire;

   logic        fuse_q;
   logic        fuse_seen_q;

   logic        timeout_irq_flag_q;
   logic        timeout_irq_enable_q;
   logic [2:0]  chg_cnt_q;
   logic        change_enable;
   logic        wdog_enable_q;
   logic        wdog_enable_eff;
   logic [3:0]  period_select_q;
   logic        wdog_reset_flag_q;
   logic        brownout_reset_flag_q;
   logic        pin_reset_flag_q;
   logic        poweron_reset_flag_q;

   logic        tick;
   logic        timeout;
   logic        counter_clear;
   logic        run;
   logic        irq_mode_timeout;
   logic        rst_mode_timeout;
   logic [7:0]  ctrl_value;
   logic [7:0]  status_value;

   // Word match on the aligned address
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      addr_hit = (addr[7:2] == reg_addr[7:2]);
   endfunction : addr_hit

   // =====================================================================
   // Write channels
   // =====================================================================
   assign wr_fire   = aw_held_q && w_held_q && !bvalid;
   assign ctrl_wr   = wr_fire && wstrb0_q && addr_hit(awaddr_q, CTRL_ADDR);
   assign status_wr = wr_fire && wstrb0_q && addr_hit(awaddr_q, STATUS_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b0;
         aw_held_q <= 1'b0;
         awaddr_q  <= 8'h0;
      end else if (awvalid && awready) begin
         awready   <= 1'b0;
         aw_held_q <= 1'b1;
         awaddr_q  <= awaddr;
      end else begin
         if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (!aw_held_q && !bvalid) begin
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready   <= 1'b0;
         w_held_q <= 1'b0;
         wdata_q  <= 8'h0;
         wstrb0_q <= 1'b0;
      end else if (wvalid && wready) begin
         wready   <= 1'b0;
         w_held_q <= 1'b1;
         wdata_q  <= wdata[7:0];
         wstrb0_q <= wstrb[0];
      end else begin
         if (wr_fire) begin
            w_held_q <= 1'b0;
         end
         if (!w_held_q && !bvalid) begin
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= (addr_hit(awaddr_q, CTRL_ADDR) || addr_hit(awaddr_q, STATUS_ADDR)) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // =====================================================================
   // Read channel
   // =====================================================================
   assign ar_fire = arvalid && arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
      end else if (ar_fire) begin
         arready <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid <= 1'b1;
         if (addr_hit(araddr, CTRL_ADDR)) begin
            rdata <= {24'h0, ctrl_value};
            rresp <= RESP_OKAY;
         end else if (addr_hit(araddr, STATUS_ADDR)) begin
            rdata <= {24'h0, status_value};
            rresp <= RESP_OKAY;
         end else begin
            rdata <= 32'h0;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // =====================================================================
   // Safety level strap, caught after reset release
   // =====================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fuse_q      <= 1'b0;
         fuse_seen_q <= 1'b0;
      end else if (!fuse_seen_q) begin
         fuse_q      <= safety_level_fuse;
         fuse_seen_q <= 1'b1;
      end
   end

   // =====================================================================
   // Change enable window
   // =====================================================================
   assign change_enable = (chg_cnt_q != 3'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chg_cnt_q <= 3'h0;
      end else if (ctrl_wr && wdata_q[CHG_EN_BIT]) begin
         chg_cnt_q <= CHG_EN_CYCLES;
      end else if (change_enable) begin
         chg_cnt_q <= chg_cnt_q - 3'h1;
      end
   end

   // =====================================================================
   // Enable and period select
   // =====================================================================
   // Level 2 forces enable; level 1 forces it while the watchdog flag stands
   assign wdog_enable_eff = wdog_enable_q || fuse_q || wdog_reset_flag_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_enable_q <= 1'b0;
      end else if (ctrl_wr) begin
         if (wdata_q[WD_EN_BIT]) begin
            wdog_enable_q <= 1'b1;
         end else if (change_enable && !fuse_q && !wdog_reset_flag_q) begin
            wdog_enable_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_select_q <= 4'h0;
      end else if (ctrl_wr && change_enable) begin
         period_select_q <= {wdata_q[PSEL_HI_BIT], wdata_q[PSEL_LO_MSB:0]};
      end
   end

   // =====================================================================
   // Time-out action
   // =====================================================================
   assign run              = wdog_enable_eff || timeout_irq_enable_q;
   assign irq_mode_timeout = timeout && timeout_irq_enable_q;
   assign rst_mode_timeout = timeout && wdog_enable_eff && !timeout_irq_enable_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_irq_enable_q <= 1'b0;
      end else if (irq_mode_timeout && wdog_enable_eff) begin
         timeout_irq_enable_q <= 1'b0;
      end else if (ctrl_wr) begin
         timeout_irq_enable_q <= wdata_q[IRQ_EN_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_irq_flag_q <= 1'b0;
      end else if (irq_mode_timeout) begin
         timeout_irq_flag_q <= 1'b1;
      end else if (irq_taken || (ctrl_wr && wdata_q[IRQ_FLAG_BIT])) begin
         timeout_irq_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_irq <= 1'b0;
      end else begin
         wdog_irq <= timeout_irq_flag_q && timeout_irq_enable_q && cpu_irq_enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_reset_pulse <= 1'b0;
      end else begin
         wdog_reset_pulse <= rst_mode_timeout;
      end
   end

   // =====================================================================
   // Reset source flags; system reset counts as power-on
   // =====================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_reset_flag_q <= 1'b0;
      end else if (rst_mode_timeout) begin
         wdog_reset_flag_q <= 1'b1;
      end else if (status_wr && !wdata_q[WDOG_FLAG_BIT]) begin
         wdog_reset_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brownout_reset_flag_q <= 1'b0;
      end else if (brownout_rst_evt) begin
         brownout_reset_flag_q <= 1'b1;
      end else if (status_wr && !wdata_q[BROWN_FLAG_BIT]) begin
         brownout_reset_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_reset_flag_q <= 1'b0;
      end else if (pin_rst_evt) begin
         pin_reset_flag_q <= 1'b1;
      end else if (status_wr && !wdata_q[PIN_FLAG_BIT]) begin
         pin_reset_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         poweron_reset_flag_q <= 1'b1;
      end else if (status_wr && !wdata_q[PON_FLAG_BIT]) begin
         poweron_reset_flag_q <= 1'b0;
      end
   end

   // =====================================================================
   // Read values
   // =====================================================================
   assign ctrl_value = {timeout_irq_flag_q, timeout_irq_enable_q, period_select_q[3], change_enable,
                        wdog_enable_eff, period_select_q[2:0]};
   assign status_value = {STATUS_RSV_ZERO, wdog_reset_flag_q, brownout_reset_flag_q,
                          pin_reset_flag_q, poweron_reset_flag_q};

   // =====================================================================
   // Tick generator and counter
   // =====================================================================
   // Tick is a clock enable in the single domain, so no crossing is needed
   assign counter_clear = wdog_restart || !run || brownout_rst_evt || pin_rst_evt ||
                          wdog_reset_pulse;

   wdog_tick_gen #(
      .DIV (TICK_DIV)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   wdog_counter u_counter (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .tick          (tick),
      .clear         (counter_clear),
      .period_select (period_select_q),
      .timeout       (timeout)
   );

endmodule : wdog_top

// file: verif/test_wdog_top.sv
// Self-checking bench for the watchdog block
`timescale 1ns/10ps
module test_wdog_top;
   import wdog_pkg::*;

   localparam int TD = 2;
   localparam int P1 = (2048 << 1) * TD;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        wdog_restart = 1'b0, cpu_irq_enable = 1'b1, irq_taken = 1'b0;
   logic        brownout_rst_evt = 1'b0, pin_rst_evt = 1'b0, safety_level_fuse = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, wdog_irq, wdog_reset_pulse;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          fails = 0;
   int          tests_run = 0;

   always #4 aclk = ~aclk;

   wdog_top #(.TICK_DIV(TD)) i_dut (
      .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .wdog_restart, .cpu_irq_enable, .irq_taken, .brownout_rst_evt, .pin_rst_evt,
      .safety_level_fuse, .wdog_irq, .wdog_reset_pulse);

   // =========================================
   // Shared tasks
   // =========================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [1:0] resp_for(input logic [7:0] a);
      return (a == CTRL_ADDR || a == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
   endfunction : resp_for

   // Waits for the answer as long as it takes; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, resp_for(a)});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check(rdata, {24'h000000, exp});
      check({30'h0, rresp}, {30'h0, resp_for(a)});
   endtask : rd

   // Counts cycles until the chosen output rises
   task automatic wait_evt(input logic irq, input int lo, input int hi);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((irq ? wdog_irq : wdog_reset_pulse) !== 1'b1 && n < hi);
      check({31'h0, n >= lo && n < hi}, 32'h1);
   endtask : wait_evt

   // =========================================
   // Scenarios
   // =========================================
   task automatic t_defaults();
      rd(CTRL_ADDR, 8'h00);
      rd(STATUS_ADDR, 8'h01);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      $display("defaults done");
   endtask : t_defaults

   task automatic t_status();
      @(posedge aclk);
      brownout_rst_evt <= 1'b1;
      pin_rst_evt <= 1'b1;
      @(posedge aclk);
      brownout_rst_evt <= 1'b0;
      pin_rst_evt <= 1'b0;
      rd(STATUS_ADDR, 8'h07);
      wr(STATUS_ADDR, 8'hff);
      rd(STATUS_ADDR, 8'h07);
      wr(STATUS_ADDR, 8'h00);
      rd(STATUS_ADDR, 8'h00);
      $display("status done");
   endtask : t_status

   task automatic t_guard();
      wr(CTRL_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h07);
      rd(CTRL_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h18);
      repeat (8) @(posedge aclk);
      wr(CTRL_ADDR, 8'h00);
      rd(CTRL_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h01);
      rd(CTRL_ADDR, 8'h01);
      $display("guard done");
   endtask : t_guard

   task automatic t_reset_mode();
      wr(CTRL_ADDR, 8'h09);
      repeat (6000) @(posedge aclk);
      wdog_restart <= 1'b1;
      @(posedge aclk);
      wdog_restart <= 1'b0;
      wait_evt(1'b0, P1 - 8, P1 + 16);
      rd(STATUS_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h01);
      rd(CTRL_ADDR, 8'h09);
      wr(STATUS_ADDR, 8'h00);
      rd(CTRL_ADDR, 8'h09);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h01);
      rd(CTRL_ADDR, 8'h01);
      $display("reset mode done");
   endtask : t_reset_mode

   task automatic t_irq();
      wr(CTRL_ADDR, 8'h41);
      wait_evt(1'b1, P1 - 8, P1 + 16);
      cpu_irq_enable <= 1'b0;
      repeat (2) @(posedge aclk);
      check({31'h0, wdog_irq}, 32'h0);
      cpu_irq_enable <= 1'b1;
      repeat (2) @(posedge aclk);
      check({31'h0, wdog_irq}, 32'h1);
      @(posedge aclk);
      irq_taken <= 1'b1;
      @(posedge aclk);
      irq_taken <= 1'b0;
      repeat (3) @(posedge aclk);
      check({31'h0, wdog_irq}, 32'h0);
      rd(CTRL_ADDR, 8'h41);
      wr(CTRL_ADDR, 8'h49);
      repeat (8400) @(posedge aclk);
      rd(CTRL_ADDR, 8'h89);
      check({31'h0, wdog_irq}, 32'h0);
      wr(CTRL_ADDR, 8'h89);
      rd(CTRL_ADDR, 8'h09);
      wait_evt(1'b0, 1, 9000);
      $display("irq mode done");
   endtask : t_irq

   task automatic t_fuse2();
      int seen;
      seen = 0;
      safety_level_fuse <= 1'b1;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(STATUS_ADDR, 8'h01);
      rd(CTRL_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h00);
      rd(CTRL_ADDR, 8'h08);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h02);
      rd(CTRL_ADDR, 8'h0a);
      wr(CTRL_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h22);
      rd(CTRL_ADDR, 8'h2a);
      wdog_restart <= 1'b1;
      @(posedge aclk);
      wdog_restart <= 1'b0;
      // A reserved code must outlast the period of its low bits
      repeat (17000) begin
         @(posedge aclk);
         if (wdog_reset_pulse === 1'b1) seen++;
      end
      check(seen, 0);
      $display("level two done");
   endtask : t_fuse2

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_defaults();
      t_status();
      t_guard();
      t_reset_mode();
      t_irq();
      t_fuse2();
      tally_and_finish();
   end

   initial begin
      repeat (100000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end
endmodule : test_wdog_top

// file: verif/wdog_checker.sv
// Port checker for the watchdog block
`timescale 1ns/10ps
module wdog_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        cpu_irq_enable,
   input wire logic        wdog_irq,
   input wire logic        wdog_reset_pulse
);
   import wdog_pkg::*;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // =========================================
   // Assertions
   // =========================================
   a_status_hi_zero:
      assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_irq_needs_gie:
      assert property (wdog_irq |-> $past(cpu_irq_enable))
      else $error("interrupt without global enable");
   a_pulse_single:
      assert property (wdog_reset_pulse |=> !wdog_reset_pulse [*8])
      else $error("reset pulse longer than one cycle");
   a_read_answer:
      assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer:
      assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   a_b_hold:
      assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_r_hold:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_w_quiet:
      assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");

   // Main scenarios
   c_reset: cover property (wdog_reset_pulse);
   c_irq: cover property (wdog_irq);
   c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : wdog_checker

bind wdog_top wdog_checker i_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
   .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .cpu_irq_enable, .wdog_irq, .wdog_reset_pulse);
